// [rtl/gpib_result_output.sv]
// Result line output, separators, logging filter, talk-only and clear hierarchy
`timescale 1ns/1ps
module gpib_result_output (
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  // Result lines from the formatter, one byte a cycle
  input wire logic line_valid_i,
  input wire logic [7:0] line_data_i,
  input wire logic line_last_i,
  input wire logic [1:0] line_class_i,
  input wire logic msg_end_i,
  // Bus state from the interface functions
  input wire logic talker_addressed_i,
  input wire logic listener_addressed_i,
  input wire logic ifc_i,
  input wire logic dcl_i,
  input wire logic sdc_i,
  input wire logic serial_clear_i,
  input wire logic cmd_waiting_i,
  // Talker byte source
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  output logic tx_end_o,
  input wire logic tx_ready_i,
  // Status and side effects
  output logic [7:0] status_byte_o,
  output logic talk_only_o,
  output logic iface_clear_o,
  output logic cmd_clear_o,
  output logic meas_reinit_o,
  output logic reload_params_o
);
  import gpib_out_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    out_state_e st;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W-1:0] last_idx;
    logic line_final;
    logic sep_pending;
    logic in_drop;
    logic out_valid;
    logic [7:0] out_byte;
    logic out_end;
    logic compat;
    logic [1:0] log_level;
    logic [1:0] addr_mode;
    logic powerup;
    logic ready;
    logic [7:0] dropped;
    logic [31:0] rdata;
    logic iface_clear;
    logic cmd_clear;
    logic meas_reinit;
    logic reload_params;
  } state_s;

  state_s s;
  state_s next_s;
  logic [7:0] line_mem [LINE_DEPTH];
  logic mem_we;
  logic [PTR_W-1:0] mem_waddr;
  logic talk_ok;
  logic send_fire;
  logic clear_any;
  logic line_ok;

  // ==========================================================================
  // Helpers
  function automatic logic log_allows(input logic [1:0] level, input logic [1:0] cls);
    logic ok;
    ok = 1'b0;
    unique case (level)
      LOG_OFF: ok = (cls == CLASS_QUERY_REPLY);
      LOG_READINGS: ok = (cls == CLASS_QUERY_REPLY) || (cls == CLASS_MEASUREMENT);
      LOG_RESULTS: ok = (cls != CLASS_COMMAND_ECHO);
      LOG_COMMANDS_AND_OUTPUTS: ok = 1'b1;
    endcase
    return ok;
  endfunction

  function automatic logic [7:0] sep_char(input logic compat);
    return compat ? CHAR_SEMICOLON : CHAR_LINE_FEED;
  endfunction

  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    return (v == 8'hff) ? v : v + 8'h01;
  endfunction

  // Talk-only needs no addressing; other talkers must stay silent then
  assign talk_ok = talker_addressed_i || (s.addr_mode == TRANSMIT_WITHOUT_ADDRESSING);
  assign send_fire = s.out_valid && talk_ok && tx_ready_i;
  // Every device clear source runs the same path
  assign clear_any = dcl_i || (sdc_i && listener_addressed_i) || serial_clear_i
    || (reg_we_i && reg_addr_i == CONTROL_ADDR && reg_wdata_i[CTL_PANEL_CLEAR_BIT]);
  // Front-panel lines pass the filter whether or not a controller exists
  assign line_ok = log_allows(s.log_level, line_class_i);

  // ==========================================================================
  // Next state
  always_comb begin
    next_s = s;
    mem_we = 1'b0;
    mem_waddr = s.wr_ptr;
    next_s.rdata = 32'h0000_0000;
    next_s.iface_clear = 1'b0;
    next_s.cmd_clear = 1'b0;
    next_s.meas_reinit = 1'b0;
    next_s.reload_params = 1'b0;
    next_s.ready = cmd_waiting_i;

    // Line intake; only one line is held, so a busy buffer drops the new line whole
    if (line_valid_i && line_ok) begin
      if (s.st == COLLECT && !s.in_drop) begin
        if (s.wr_ptr == PTR_LAST && !line_last_i) begin
          next_s.in_drop = 1'b1;
          next_s.wr_ptr = '0;
          next_s.dropped = sat_inc(s.dropped);
        end else begin
          mem_we = 1'b1;
          if (line_last_i) begin
            next_s.last_idx = s.wr_ptr;
            next_s.line_final = msg_end_i;
            next_s.wr_ptr = '0;
            next_s.rd_ptr = '0;
            next_s.out_valid = 1'b1;
            next_s.out_end = 1'b0;
            if (s.sep_pending) begin
              next_s.st = SEND_SEP;
              next_s.out_byte = sep_char(s.compat);
            end else begin
              next_s.st = SEND_BODY;
              next_s.out_byte = (s.wr_ptr == '0) ? line_data_i : line_mem[0];
            end
          end else begin
            next_s.wr_ptr = s.wr_ptr + 7'h01;
          end
        end
      end else begin
        if (!s.in_drop) begin
          next_s.dropped = sat_inc(s.dropped);
        end
        next_s.in_drop = !line_last_i;
      end
    end

    // Byte output towards the talker
    if (send_fire) begin
      unique case (s.st)
        SEND_SEP: begin
          next_s.st = SEND_BODY;
          next_s.rd_ptr = '0;
          next_s.out_byte = line_mem[0];
        end
        SEND_BODY: begin
          if (s.rd_ptr != s.last_idx) begin
            next_s.rd_ptr = s.rd_ptr + 7'h01;
            next_s.out_byte = line_mem[s.rd_ptr + 7'h01];
          end else if (s.line_final) begin
            next_s.st = SEND_TERM;
            next_s.out_byte = CHAR_LINE_FEED;
            next_s.out_end = 1'b1;
          end else begin
            // Separator waits for the next line so none trails a message
            next_s.st = COLLECT;
            next_s.out_valid = 1'b0;
            next_s.sep_pending = 1'b1;
          end
        end
        SEND_TERM: begin
          next_s.st = COLLECT;
          next_s.out_valid = 1'b0;
          next_s.out_end = 1'b0;
          next_s.sep_pending = 1'b0;
        end
        COLLECT: begin
          next_s.out_valid = 1'b0;
        end
      endcase
    end

    // Interface clear drops the talker byte so a device clear can get through
    if (ifc_i) begin
      next_s.st = COLLECT;
      next_s.out_valid = 1'b0;
      next_s.out_end = 1'b0;
      next_s.iface_clear = 1'b1;
    end

    // Device clear flushes buffers and formatting; bus config is kept
    if (clear_any) begin
      next_s.st = COLLECT;
      next_s.out_valid = 1'b0;
      next_s.out_end = 1'b0;
      next_s.wr_ptr = '0;
      next_s.rd_ptr = '0;
      next_s.sep_pending = 1'b0;
      next_s.in_drop = 1'b0;
      next_s.cmd_clear = 1'b1;
      mem_we = 1'b0;
    end

    // Register writes
    if (reg_we_i) begin
      unique case (reg_addr_i)
        CONFIG_ADDR: begin
          next_s.compat = reg_wdata_i[CFG_COMPAT_BIT];
          next_s.log_level = reg_wdata_i[CFG_LOG_LSB +: 2];
          next_s.addr_mode = reg_wdata_i[CFG_ADDR_LSB +: 2];
        end
        CONTROL_ADDR: begin
          if (reg_wdata_i[CTL_RESET_CMD_BIT]) begin
            // Bus settings (compat, log level, addressing) stay as they are
            next_s.meas_reinit = 1'b1;
            next_s.reload_params = 1'b1;
            next_s.powerup = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Register reads, answered the next cycle
    if (reg_re_i) begin
      unique case (reg_addr_i)
        CONFIG_ADDR: begin
          next_s.rdata[CFG_COMPAT_BIT] = s.compat;
          next_s.rdata[CFG_LOG_LSB +: 2] = s.log_level;
          next_s.rdata[CFG_ADDR_LSB +: 2] = s.addr_mode;
        end
        STATUS_ADDR: begin
          next_s.rdata[STA_POWERUP_BIT] = s.powerup;
          next_s.rdata[STA_MAV_BIT] = s.out_valid;
          next_s.rdata[STA_READY_BIT] = s.ready;
          next_s.rdata[STA_TRANSMIT_WITHOUT_ADDRESSING_BIT] = (s.addr_mode == TRANSMIT_WITHOUT_ADDRESSING);
          next_s.rdata[STA_DROP_LSB +: 8] = s.dropped;
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s <= '0;
      s.st <= COLLECT;
      s.compat <= RST_COMPAT;
      s.log_level <= RST_LOG_LEVEL;
      s.addr_mode <= RST_ADDR_MODE;
      s.powerup <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Line store has no reset; contents only matter up to and including last_idx
  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      line_mem[mem_waddr] <= line_data_i;
    end
  end

  // ==========================================================================
  // Outputs
  assign reg_rdata_o = s.rdata;
  assign tx_valid_o = s.out_valid && talk_ok;
  assign tx_data_o = s.out_byte;
  assign tx_end_o = s.out_end;
  assign talk_only_o = (s.addr_mode == TRANSMIT_WITHOUT_ADDRESSING);
  always_comb begin
    status_byte_o = 8'h00;
    status_byte_o[SB_READY_BIT] = s.ready;
    status_byte_o[SB_MAV_BIT] = s.out_valid;
  end
  assign iface_clear_o = s.iface_clear;
  assign cmd_clear_o = s.cmd_clear;
  assign meas_reinit_o = s.meas_reinit;
  assign reload_params_o = s.reload_params;

endmodule // gpib_result_output

// [common/gpib_out_pkg.sv]
// Constants and types for the bus result output and clear block
// ============================================================================
package gpib_out_pkg;

  // ==========================================================================
  // Register map (byte addresses, 32-bit words)
  localparam logic [3:0] CONFIG_ADDR = 4'h0;
  localparam logic [3:0] STATUS_ADDR = 4'h4;
  localparam logic [3:0] CONTROL_ADDR = 4'h8;

  // CONFIG fields
  localparam int CFG_COMPAT_BIT = 0;
  localparam int CFG_LOG_LSB = 1;
  localparam int CFG_ADDR_LSB = 3;

  // STATUS fields
  localparam int STA_POWERUP_BIT = 0;
  localparam int STA_MAV_BIT = 1;
  localparam int STA_READY_BIT = 2;
  localparam int STA_TRANSMIT_WITHOUT_ADDRESSING_BIT = 3;
  localparam int STA_DROP_LSB = 8;

  // CONTROL fields (write only, self clearing)
  localparam int CTL_RESET_CMD_BIT = 0;
  localparam int CTL_PANEL_CLEAR_BIT = 1;

  // Status byte positions
  localparam int SB_READY_BIT = 4;
  localparam int SB_MAV_BIT = 7;

  // Logging levels
  localparam logic [1:0] LOG_OFF = 2'h0;
  localparam logic [1:0] LOG_READINGS = 2'h1;
  localparam logic [1:0] LOG_RESULTS = 2'h2;
  localparam logic [1:0] LOG_COMMANDS_AND_OUTPUTS = 2'h3;

  // Addressing select values
  localparam logic [1:0] PRIMARY_ADDRESS_ONLY = 2'h0;
  localparam logic [1:0] PRIMARY_AND_SECONDARY_ADDRESS = 2'h1;
  localparam logic [1:0] TRANSMIT_WITHOUT_ADDRESSING = 2'h2;

  // Line classes from the formatter
  localparam logic [1:0] CLASS_QUERY_REPLY = 2'h0;
  localparam logic [1:0] CLASS_MEASUREMENT = 2'h1;
  localparam logic [1:0] CLASS_SHOW = 2'h2;
  localparam logic [1:0] CLASS_COMMAND_ECHO = 2'h3;

  // Characters
  localparam logic [7:0] CHAR_SEMICOLON = 8'h3b;
  localparam logic [7:0] CHAR_LINE_FEED = 8'h0a;

  // Reset values
  localparam logic RST_COMPAT = 1'b0;
  localparam logic [1:0] RST_LOG_LEVEL = LOG_READINGS;
  localparam logic [1:0] RST_ADDR_MODE = PRIMARY_ADDRESS_ONLY;

  // Line buffer
  localparam int LINE_DEPTH = 128;
  localparam int PTR_W = 7;
  localparam logic [PTR_W-1:0] PTR_LAST = 7'h7f;

  typedef enum logic [1:0] {
    COLLECT,
    SEND_SEP,
    SEND_BODY,
    SEND_TERM
  } out_state_e;

endpackage

// [bench/gpib_result_output_properties.sv]
// Port assertions for the result output block
`timescale 1ns/1ps
module gpib_result_output_properties (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic listener_addressed_i,
  input wire logic ifc_i,
  input wire logic dcl_i,
  input wire logic sdc_i,
  input wire logic serial_clear_i,
  input wire logic cmd_waiting_i,
  input wire logic [7:0] status_byte_o,
  input wire logic iface_clear_o,
  input wire logic cmd_clear_o,
  input wire logic meas_reinit_o,
  input wire logic reload_params_o
);
  import gpib_out_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // ======
  // Sequences
  sequence s_reset_write;
    reg_we_i && reg_addr_i == CONTROL_ADDR && reg_wdata_i[CTL_RESET_CMD_BIT];
  endsequence
  sequence s_idle_two;
    cmd_waiting_i [*2];
  endsequence
  sequence s_busy_two;
    !cmd_waiting_i [*2];
  endsequence
  // ======
  // Clears
  chk_dev_clear: assert property (dcl_i |=> cmd_clear_o)
    else $error("device clear gave no command clear");
  chk_sel_clear: assert property (sdc_i && listener_addressed_i |=> cmd_clear_o)
    else $error("selective clear gave no command clear");
  chk_serial_clear: assert property (serial_clear_i |=> cmd_clear_o)
    else $error("serial clear gave no command clear");
  chk_ifc_pulse: assert property ($rose(ifc_i) |=> iface_clear_o)
    else $error("interface clear gave no pulse");
  // ======
  // Reset command
  chk_reset_cmd: assert property (s_reset_write |=> meas_reinit_o && reload_params_o)
    else $error("reset command gave no reinit pulses");
  chk_reinit_cause: assert property (
    !(reg_we_i && reg_addr_i == CONTROL_ADDR && reg_wdata_i[CTL_RESET_CMD_BIT])
    |=> !meas_reinit_o)
    else $error("reinit pulse without reset command");
  // ======
  // Ready bit follows the command processor
  chk_ready_set: assert property (s_idle_two |=> status_byte_o[SB_READY_BIT])
    else $error("ready bit low while waiting");
  chk_ready_clr: assert property (s_busy_two |=> !status_byte_o[SB_READY_BIT])
    else $error("ready bit high while busy");
endmodule // gpib_result_output_properties

bind gpib_result_output gpib_result_output_properties u_gpib_result_output_properties (
  .clk_i, .arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .listener_addressed_i, .ifc_i,
  .dcl_i, .sdc_i, .serial_clear_i, .cmd_waiting_i, .status_byte_o, .iface_clear_o,
  .cmd_clear_o, .meas_reinit_o, .reload_params_o);

// [bench/gpib_bus_listener.sv]
// Controller and listener model on the talker side
`timescale 1ns/1ps
module gpib_bus_listener (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic stall_i,
  input wire logic talk_en_i,
  output logic tx_ready_o,
  output logic talker_addressed_o
);
  // ======
  // Handshake, prompt or slow at random
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_ready_o <= 1'b0;
      talker_addressed_o <= 1'b0;
    end else begin
      // Only ever listens, so talk-only owns the bus
      tx_ready_o <= !stall_i && ($urandom_range(3) != 0);
      talker_addressed_o <= talk_en_i;
    end
  end
endmodule // gpib_bus_listener

// [bench/test_gpib_result_output.sv]
// Self-checking bench for the result output block
`timescale 1ns/1ps
module test_gpib_result_output;
  import gpib_out_pkg::*;
  logic clk_i, arst_n_i, reg_we_i, reg_re_i, line_valid_i, line_last_i, msg_end_i;
  logic [3:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  logic [7:0] line_data_i, tx_data_o, status_byte_o;
  logic [1:0] line_class_i;
  logic talker_addressed_i, listener_addressed_i, ifc_i, dcl_i, sdc_i, serial_clear_i;
  logic cmd_waiting_i, tx_valid_o, tx_end_o, tx_ready_i, talk_only_o, iface_clear_o;
  logic cmd_clear_o, meas_reinit_o, reload_params_o, stall, talk_en, rd_d, compat, sep_pend;
  logic [8:0] tq[$];
  logic [31:0] rq[$];
  int num_errors, total_checks;

  gpib_result_output u_gpib_result_output (.clk_i, .arst_n_i, .reg_addr_i, .reg_wdata_i,
    .reg_we_i, .reg_re_i, .reg_rdata_o, .line_valid_i, .line_data_i, .line_last_i,
    .line_class_i, .msg_end_i, .talker_addressed_i, .listener_addressed_i, .ifc_i, .dcl_i,
    .sdc_i, .serial_clear_i, .cmd_waiting_i, .tx_valid_o, .tx_data_o, .tx_end_o, .tx_ready_i,
    .status_byte_o, .talk_only_o, .iface_clear_o, .cmd_clear_o, .meas_reinit_o,
    .reload_params_o);
  gpib_bus_listener u_gpib_bus_listener (.clk_i, .arst_n_i, .stall_i(stall),
    .talk_en_i(talk_en), .tx_ready_o(tx_ready_i), .talker_addressed_o(talker_addressed_i));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // ======
  // Checking
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Pre-update values at the edge, as the design samples them
  always @(posedge clk_i) begin
    rd_d <= reg_re_i;
    if (rd_d) check("read data", rq.pop_front(), reg_rdata_o);
    if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
      if (tq.size() == 0) check("unexpected byte", 32'hffffffff, {23'h0, tx_end_o, tx_data_o});
      else check("bus byte", {23'h0, tq.pop_front()}, {23'h0, tx_end_o, tx_data_o});
    end
  end
  // ======
  // Drivers
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_we_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_i);
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    rq.push_back(e);
    @(posedge clk_i);
    reg_re_i <= 1'b0;
  endtask
  task automatic pulse(input int k);
    @(posedge clk_i);
    case (k)
      0: dcl_i <= 1'b1;
      1: sdc_i <= 1'b1;
      2: serial_clear_i <= 1'b1;
      default: ifc_i <= 1'b1;
    endcase
    @(posedge clk_i);
    {dcl_i, sdc_i, serial_clear_i, ifc_i} <= 4'h0;
  endtask
  task automatic send_line(input logic [1:0] cls, input int n, input logic mend, input logic keep);
    logic [7:0] b;
    if (keep && sep_pend) tq.push_back({1'b0, compat ? CHAR_SEMICOLON : CHAR_LINE_FEED});
    for (int i = 0; i < n; i++) begin
      b = 8'($urandom);
      @(posedge clk_i);
      line_valid_i <= 1'b1;
      line_data_i <= b;
      line_class_i <= cls;
      line_last_i <= (i == n - 1);
      msg_end_i <= mend;
      if (keep) tq.push_back({1'b0, b});
    end
    @(posedge clk_i);
    line_valid_i <= 1'b0;
    line_last_i <= 1'b0;
    if (keep && mend) tq.push_back({1'b1, CHAR_LINE_FEED});
    if (keep) sep_pend = !mend;
  endtask
  task automatic wait_empty();
    int t;
    t = 0;
    while ((tq.size() != 0 || status_byte_o[SB_MAV_BIT] !== 1'b0) && t < 3000) begin
      @(posedge clk_i);
      t++;
    end
    if (t >= 3000) begin
      check("drain", 32'h0, 32'(tq.size() + 1));
      print_verdict();
    end
    repeat (4) @(posedge clk_i);
  endtask
  // ======
  // Scenarios
  initial begin
    {reg_we_i, reg_re_i, line_valid_i, line_last_i, msg_end_i, rd_d} = 6'h0;
    {listener_addressed_i, ifc_i, dcl_i, sdc_i, serial_clear_i} = 5'h0;
    {compat, sep_pend, stall, arst_n_i} = 4'h0;
    {talk_en, cmd_waiting_i} = 2'h3;
    {reg_addr_i, reg_wdata_i, line_data_i, line_class_i} = '0;
    void'($urandom(32'h6d78544f));
    repeat (12) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rd(CONFIG_ADDR, 32'h2);
    rd(STATUS_ADDR, 32'h5);
    rd(4'hc, 32'h0);
    wr(STATUS_ADDR, 32'hff);
    rd(STATUS_ADDR, 32'h5);
    for (int c = 0; c < 2; c++) begin
      compat = 1'(c);
      wr(CONFIG_ADDR, {27'h0, PRIMARY_ADDRESS_ONLY, LOG_READINGS, compat});
      for (int k = 0; k < 3; k++) begin
        send_line(CLASS_MEASUREMENT, 2 + k, k == 2, 1'b1);
        wait_empty();
      end
    end
    compat = 1'b0;
    for (int lv = 0; lv < 4; lv++) begin
      wr(CONFIG_ADDR, {27'h0, PRIMARY_ADDRESS_ONLY, 2'(lv), 1'b0});
      for (int k = 0; k < 4; k++) begin
        send_line(2'(k), 1 + $urandom_range(3), 1'b1, k <= lv);
        wait_empty();
      end
    end
    // Not addressed: the line must wait
    talk_en <= 1'b0;
    send_line(CLASS_MEASUREMENT, 2, 1'b1, 1'b1);
    repeat (20) @(posedge clk_i);
    check("held bytes", 32'd3, 32'(tq.size()));
    talk_en <= 1'b1;
    wait_empty();
    talk_en <= 1'b0;
    wr(CONFIG_ADDR, {27'h0, TRANSMIT_WITHOUT_ADDRESSING, LOG_READINGS, 1'b0});
    send_line(CLASS_MEASUREMENT, 3, 1'b1, 1'b1);
    wait_empty();
    rd(STATUS_ADDR, 32'hd);
    check("talk only", 32'h1, {31'h0, talk_only_o});
    // Device clear flushes a stalled line; selective, serial and panel clears follow
    stall <= 1'b1;
    send_line(CLASS_MEASUREMENT, 4, 1'b1, 1'b0);
    cmd_waiting_i <= 1'b0;
    pulse(0);
    listener_addressed_i <= 1'b1;
    pulse(1);
    pulse(2);
    wr(CONTROL_ADDR, 32'h2);
    cmd_waiting_i <= 1'b1;
    stall <= 1'b0;
    repeat (20) @(posedge clk_i);
    rd(STATUS_ADDR, 32'hd);
    // Clear hierarchy ending in the reset command
    talk_en <= 1'b1;
    pulse(3);
    pulse(0);
    wr(CONFIG_ADDR, {27'h0, PRIMARY_AND_SECONDARY_ADDRESS, LOG_RESULTS, 1'b1});
    wr(CONTROL_ADDR, 32'h1);
    rd(STATUS_ADDR, 32'h4);
    rd(CONFIG_ADDR, 32'hd);
    check("talk only off", 32'h0, {31'h0, talk_only_o});
    compat = 1'b1;
    // Slow reader: second line is lost whole
    stall <= 1'b1;
    send_line(CLASS_MEASUREMENT, 2, 1'b1, 1'b1);
    repeat (2) @(posedge clk_i);
    send_line(CLASS_MEASUREMENT, 3, 1'b1, 1'b0);
    rd(STATUS_ADDR, 32'h106);
    stall <= 1'b0;
    wait_empty();
    print_verdict();
  end
endmodule // test_gpib_result_output
